// file: lpm_ctrl.sv
// low power mode controller: wait/stop entry, clock gating, port hold, wake-up
// Operation
// - port direction and output data stay frozen during wait and stop mode.
// - writing 1 to the all-clock-stop bit halts all clocks after the prefetch queue drains.
// - wait mode begins only after a drain window in which prefetched instructions may run.
// - with the peripheral-stop-in-wait bit set, peripheral clocks stop in wait, the sub clock divide-by-32 does not.
// - while the non-maskable interrupt pin is low the all-clock-stop bit is forced to 0.
//
// The address map and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
module lpm_ctrl
    import lpm_pkg::*;
(
    input wire logic sys_clk,              // 40 MHz clock
    input wire logic srst,                 // sync reset, high
    input wire logic hsel,                 // ahb select
    input wire logic [31:0] haddr,         // ahb address
    input wire logic [1:0] htrans,         // ahb transfer type
    input wire logic hwrite,               // ahb write
    input wire logic [2:0] hsize,          // ahb size
    input wire logic [31:0] hwdata,        // ahb write data
    input wire logic hready,               // ahb ready in
    output logic [31:0] hrdata,            // ahb read data
    output logic hreadyout,                // ahb ready out
    output logic hresp,                    // ahb response
    input wire logic nmi_n_pin,            // non-maskable interrupt pin, async
    input wire logic wake_irq,             // enabled interrupt request, async
    output logic cpu_clk_en,               // cpu clock enable
    output logic periph_clk_en,            // peripheral clock enable
    output logic subclk_div32_en,          // subclock_div32_clock enable
    output logic [7:0] port_out,           // port output data
    output logic [7:0] port_dir,           // port direction
    output logic in_wait,                  // wait mode flag
    output logic in_stop                   // stop mode flag
);
    import lpm_pkg::*;

    // ahb address phase capture
    logic ap_wr_ff, ap_rd_ff, nxt_ap_wr, nxt_ap_rd;
    logic [7:0] ap_addr_ff, nxt_ap_addr;
    logic [7:0] clk0_ff, nxt_clk0, clk1_ff, nxt_clk1, port_ff, nxt_port, dir_ff, nxt_dir;
    logic nmi_s1_ff, nmi_s2_ff, irq_s1_ff, irq_s2_ff;
    lpm_state_t st_ff, nxt_st;
    logic [2:0] cnt_ff, nxt_cnt;
    logic [4:0] div_ff, nxt_div;
    logic [31:0] rdata_ff, nxt_rdata;
    logic wr_clk1, wr_cmd, stop_req, wait_req;

    // synchronisers, first stage read only by the second
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            nmi_s1_ff <= 1'b1;
            nmi_s2_ff <= 1'b1;
            irq_s1_ff <= 1'b0;
            irq_s2_ff <= 1'b0;
        end else begin
            nmi_s1_ff <= nmi_n_pin;
            nmi_s2_ff <= nmi_s1_ff;
            irq_s1_ff <= wake_irq;
            irq_s2_ff <= irq_s1_ff;
        end
    end

    assign wr_clk1 = ap_wr_ff && (ap_addr_ff == LPM_OFF_CLK1);
    assign wr_cmd = ap_wr_ff && (ap_addr_ff == LPM_OFF_CMD);
    assign stop_req = wr_clk1 && hwdata[LPM_BIT_ACS] && nmi_s2_ff;
    assign wait_req = wr_cmd && hwdata[LPM_BIT_WAITCMD];

    // register file next values; data phase writes are zero wait state
    always_comb begin
        nxt_ap_wr = hready && hsel && htrans[1] && hwrite;
        nxt_ap_rd = hready && hsel && htrans[1] && !hwrite;
        nxt_ap_addr = hready ? haddr[7:0] : ap_addr_ff;
        nxt_clk0 = clk0_ff;
        nxt_clk1 = clk1_ff;
        nxt_port = port_ff;
        nxt_dir = dir_ff;
        if (ap_wr_ff && ap_addr_ff == LPM_OFF_CLK0) begin
            nxt_clk0 = hwdata[7:0];
        end
        if (wr_clk1) begin
            nxt_clk1 = hwdata[7:0];
        end
        if (st_ff == LPM_RUN || st_ff == LPM_WDRAIN || st_ff == LPM_SDRAIN) begin
            if (ap_wr_ff && ap_addr_ff == LPM_OFF_PORT) begin
                nxt_port = hwdata[7:0];
            end
            if (ap_wr_ff && ap_addr_ff == LPM_OFF_DIR) begin
                nxt_dir = hwdata[7:0];
            end
        end
        if (!nmi_s2_ff) begin
            nxt_clk1[LPM_BIT_ACS] = 1'b0;
        end
        if (st_ff == LPM_STOP && irq_s2_ff) begin
            nxt_clk1[LPM_BIT_ACS] = 1'b0;
        end
        nxt_rdata = 32'h0000_0000;
        if (nxt_ap_rd) begin
            case (haddr[7:0])
                LPM_OFF_CLK0: nxt_rdata = {24'h00_0000, clk0_ff};
                LPM_OFF_CLK1: nxt_rdata = {24'h00_0000, clk1_ff};
                LPM_OFF_STAT: nxt_rdata = {29'h0000_0000, st_ff};
                LPM_OFF_PORT: nxt_rdata = {24'h00_0000, port_ff};
                LPM_OFF_DIR: nxt_rdata = {24'h00_0000, dir_ff};
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    // power state machine next values
    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        case (st_ff)
            LPM_RUN: begin
                if (stop_req) begin
                    nxt_st = LPM_SDRAIN;
                    nxt_cnt = LPM_QUEUE_CNT;
                end else if (wait_req) begin
                    nxt_st = LPM_WDRAIN;
                    nxt_cnt = LPM_QUEUE_CNT;
                end
            end
            LPM_WDRAIN: begin
                if (cnt_ff <= 3'h1) begin
                    nxt_st = LPM_WAIT;
                end
                nxt_cnt = cnt_ff - 3'h1;
            end
            LPM_SDRAIN: begin
                // nmi low during drain aborts stop
                if (!nmi_s2_ff) begin
                    nxt_st = LPM_RUN;
                end else if (cnt_ff <= 3'h1) begin
                    nxt_st = LPM_STOP;
                end
                nxt_cnt = cnt_ff - 3'h1;
            end
            LPM_WAIT, LPM_STOP: begin
                if (irq_s2_ff) begin
                    nxt_st = LPM_RUN;
                end
            end
            default: nxt_st = LPM_RUN;
        endcase
        // sub clock divider keeps running except in stop
        nxt_div = (st_ff == LPM_STOP) ? div_ff : div_ff + 5'h01;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ap_wr_ff <= 1'b0;
            ap_rd_ff <= 1'b0;
            ap_addr_ff <= 8'h00;
            clk0_ff <= LPM_CLK0_RST;
            clk1_ff <= LPM_CLK1_RST;
            port_ff <= LPM_PORT_RST;
            dir_ff <= LPM_DIR_RST;
            st_ff <= LPM_RUN;
            cnt_ff <= 3'h0;
            div_ff <= 5'h00;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ap_wr_ff <= nxt_ap_wr;
            ap_rd_ff <= nxt_ap_rd;
            ap_addr_ff <= nxt_ap_addr;
            clk0_ff <= nxt_clk0;
            clk1_ff <= nxt_clk1;
            port_ff <= nxt_port;
            dir_ff <= nxt_dir;
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            div_ff <= nxt_div;
            rdata_ff <= nxt_rdata;
        end
    end

    // bus answers: always ready, always okay
    assign hrdata = rdata_ff;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign port_out = port_ff;
    assign port_dir = dir_ff;
    assign in_wait = (st_ff == LPM_WAIT);
    assign in_stop = (st_ff == LPM_STOP);
    assign cpu_clk_en = !(in_wait || in_stop);
    assign periph_clk_en = !in_stop && !(in_wait && clk0_ff[LPM_BIT_PCSW]);
    assign subclk_div32_en = !in_stop && (div_ff == 5'h1F);

    // stop drain: drain state, then stop or an nmi abort inside the window
    sequence seq_stop_drain;
        (st_ff == LPM_SDRAIN) ##[1:4] (in_stop || st_ff == LPM_RUN);
    endsequence
    // wait drain: four running cycles, then wait; nothing aborts it
    sequence seq_wait_drain;
        !in_wait [*4] ##1 in_wait;
    endsequence

    AST_PORT_HOLD: assert property (@(posedge sys_clk) disable iff (srst)
        (in_wait || in_stop) |=> $stable(port_out) && $stable(port_dir))
        else $error("port state changed in low power mode");
    AST_STOP_ENTRY: assert property (@(posedge sys_clk) disable iff (srst)
        (st_ff == LPM_RUN && stop_req) |-> ##1 seq_stop_drain)
        else $error("stop not entered after drain");
    AST_WAIT_DRAIN: assert property (@(posedge sys_clk) disable iff (srst)
        (st_ff == LPM_RUN && wait_req && !stop_req) |=> seq_wait_drain)
        else $error("wait timing after drain wrong");
    AST_PERIPH_GATE: assert property (@(posedge sys_clk) disable iff (srst)
        in_wait |-> (periph_clk_en == !clk0_ff[LPM_BIT_PCSW]) && !cpu_clk_en)
        else $error("peripheral clock gating wrong in wait");
    AST_NMI_FORCE: assert property (@(posedge sys_clk) disable iff (srst)
        (!nmi_s2_ff && !$past(srst)) |=> !clk1_ff[LPM_BIT_ACS])
        else $error("stop bit set while nmi low");
    AST_WAKE: assert property (@(posedge sys_clk) disable iff (srst)
        ((in_wait || in_stop) && irq_s2_ff) |=> cpu_clk_en)
        else $error("no wake on interrupt");
endmodule : lpm_ctrl

// file: lpm_pkg.sv
// package: register map, field positions and timing for the low power mode controller
package lpm_pkg;
    localparam logic [7:0] LPM_OFF_CLK0 = 8'h00;          // clock_mode_reg0
    localparam logic [7:0] LPM_OFF_CLK1 = 8'h04;          // clock_mode_reg1
    localparam logic [7:0] LPM_OFF_CMD = 8'h08;           // wait command strobe
    localparam logic [7:0] LPM_OFF_STAT = 8'h0C;          // status
    localparam logic [7:0] LPM_OFF_PORT = 8'h10;          // port output data
    localparam logic [7:0] LPM_OFF_DIR = 8'h14;           // port direction
    localparam int LPM_BIT_PCSW = 2;                      // periph_clock_stop_in_wait_bit
    localparam int LPM_BIT_ACS = 0;                       // all_clock_stop_bit
    localparam int LPM_BIT_WAITCMD = 0;                   // write 1 executes wait
    localparam logic [7:0] LPM_CLK0_RST = 8'h00;
    localparam logic [7:0] LPM_CLK1_RST = 8'h00;
    localparam logic [7:0] LPM_PORT_RST = 8'h00;
    localparam logic [7:0] LPM_DIR_RST = 8'h00;
    localparam int LPM_CLK_MHZ = 40;
    localparam int LPM_QUEUE_NS = 100;                    // prefetch drain window before entry
    localparam int LPM_QUEUE_CYC = (LPM_QUEUE_NS * LPM_CLK_MHZ + 999) / 1000;
    localparam logic [2:0] LPM_QUEUE_CNT = 3'(LPM_QUEUE_CYC);
    typedef enum logic [2:0] {LPM_RUN, LPM_WDRAIN, LPM_WAIT, LPM_SDRAIN, LPM_STOP} lpm_state_t;
endpackage : lpm_pkg

// file: test_low_power_mode_control.sv
// testbench: bus-driven checks of the low power mode controller against a register model
`timescale 1ns/1ps
module test_low_power_mode_control;
    import lpm_pkg::*;
    logic sys_clk, srst, hsel, hwrite, hready, nmi_n_pin, wake_irq, hreadyout, hresp, lp;
    logic cpu_clk_en, periph_clk_en, subclk_div32_en, in_wait, in_stop;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] port_out, port_dir, pv, dv;
    logic [31:0] mdl [8];
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int seen;
    lpm_ctrl lpm_ctrl_i (.sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .nmi_n_pin(nmi_n_pin), .wake_irq(wake_irq),
        .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .subclk_div32_en(subclk_div32_en),
        .port_out(port_out), .port_dir(port_dir), .in_wait(in_wait), .in_stop(in_stop));
    // one slave only, so its ready is the bus ready
    assign hready = hreadyout;
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // hang guard, the whole run needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // single word transfer; no cycle count assumed, waits on ready
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        hsel <= 1'b1; htrans <= 2'b10; haddr <= {24'h0, a}; hwrite <= wr; hsize <= 3'b010;
        do @(posedge sys_clk); while (hready !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
        do @(posedge sys_clk); while (hready !== 1'b1);
        rd = hrdata;
        check(32'(hresp), 32'h0);
    endtask : xfer
    // model takes port, direction and clk0 writes unless in a low power mode
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        if (!lp && (a == LPM_OFF_PORT || a == LPM_OFF_DIR || a == LPM_OFF_CLK0)) mdl[a[4:2]] = d & 32'hFF;
        // stop bit refused while nmi low
        if (!lp && a == LPM_OFF_CLK1) mdl[1] = d & (nmi_n_pin ? 32'hFF : 32'hFE);
    endtask : wr
    task automatic rdc(input logic [7:0] a);
        xfer(1'b0, a, 32'h0);
        check(rd, mdl[a[4:2]]);
    endtask : rdc
    task automatic settle(input logic w, input logic s);
        for (int i = 0; i < 12 && {in_wait, in_stop} !== {w, s}; i++) @(posedge sys_clk);
        check({in_wait, in_stop}, {w, s});
    endtask : settle
    task automatic pulses();
        seen = 0;
        repeat (40) begin
            @(posedge sys_clk);
            if (subclk_div32_en === 1'b1) seen++;
        end
    endtask : pulses
    task automatic complete_run();
        $display("fail_count=%0d n_tests=%0d", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    // main sequence: reset image, wait entry and wake, refused and real stop
    initial begin
        srst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'b010;
        hwdata = 32'h0; nmi_n_pin = 1'b1; wake_irq = 1'b0; lp = 1'b0;
        foreach (mdl[i]) mdl[i] = 32'h0;
        void'($urandom(32'h77D82D3E));
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        for (int i = 0; i < 7; i++) if (i != 2) rdc(8'(i * 4));
        check({cpu_clk_en, periph_clk_en, in_wait, in_stop}, 4'b1100);
        pv = 8'($urandom);
        dv = 8'($urandom);
        wr(LPM_OFF_PORT, {24'h0, pv});
        wr(LPM_OFF_DIR, {24'h0, dv});
        rdc(LPM_OFF_PORT);
        rdc(LPM_OFF_DIR);
        wr(LPM_OFF_CLK0, 32'h04);
        wr(LPM_OFF_CMD, 32'h01);
        repeat (LPM_QUEUE_CYC) @(posedge sys_clk);
        check({in_wait, cpu_clk_en}, 2'b01);
        @(posedge sys_clk);
        check(in_wait, 1'b1);
        settle(1'b1, 1'b0);
        lp = 1'b1;
        mdl[3] = 32'h2;
        check({cpu_clk_en, periph_clk_en}, 2'b00);
        pulses();
        check(32'(seen > 0), 32'h1);
        wr(LPM_OFF_PORT, {24'h0, ~pv});
        rdc(LPM_OFF_PORT);
        check({port_out, port_dir}, {pv, dv});
        rdc(LPM_OFF_STAT);
        wake_irq <= 1'b1;
        settle(1'b0, 1'b0);
        check(cpu_clk_en, 1'b1);
        wake_irq <= 1'b0;
        lp = 1'b0;
        mdl[3] = 32'h0;
        nmi_n_pin <= 1'b0;
        repeat (4) @(posedge sys_clk);
        wr(LPM_OFF_CLK1, 32'h01);
        repeat (10) @(posedge sys_clk);
        check(in_stop, 1'b0);
        rdc(LPM_OFF_CLK1);
        nmi_n_pin <= 1'b1;
        repeat (4) @(posedge sys_clk);
        wr(LPM_OFF_CLK1, 32'h01);
        repeat (LPM_QUEUE_CYC) @(posedge sys_clk);
        check({in_stop, cpu_clk_en}, 2'b01);
        @(posedge sys_clk);
        check(in_stop, 1'b1);
        settle(1'b0, 1'b1);
        lp = 1'b1;
        mdl[3] = 32'h4;
        check({cpu_clk_en, periph_clk_en}, 2'b00);
        pulses();
        check(32'(seen), 32'h0);
        wr(LPM_OFF_DIR, {24'h0, ~dv});
        check({port_out, port_dir}, {pv, dv});
        rdc(LPM_OFF_STAT);
        wake_irq <= 1'b1;
        settle(1'b0, 1'b0);
        wake_irq <= 1'b0;
        lp = 1'b0;
        mdl[3] = 32'h0;
        // stop bit clears itself on wake
        mdl[1] = mdl[1] & 32'hFE;
        rdc(LPM_OFF_CLK1);
        wr(LPM_OFF_CLK0, 32'h00);
        wr(LPM_OFF_CMD, 32'h01);
        settle(1'b1, 1'b0);
        check({cpu_clk_en, periph_clk_en}, 2'b01);
        wake_irq <= 1'b1;
        settle(1'b0, 1'b0);
        wake_irq <= 1'b0;
        complete_run();
    end
endmodule : test_low_power_mode_control
